// ==== hw/bcd_field_regs.svh ====
// Constants of the decimal field arithmetic unit
`ifndef BCD_FIELD_REGS_SVH
`define BCD_FIELD_REGS_SVH
`define BCD_CHAR_W 6
`define BCD_WORD_W 24
`define BCD_WADDR_W 15
`define BCD_CADDR_W 17
`define BCD_ACC_W 53
`define BCD_ACC_SIGN 52
`define BCD_LEN_W 4
`define BCD_OP_LOAD 6'h34
`define BCD_OP_STORE 6'h35
`define BCD_OP_ADD 6'h36
`define BCD_OP_SUB 6'h37
`define BCD_OP_SETLEN 6'h38
`define BCD_SUB_SETLEN 3'h7
`define BCD_OP_SHIFT 6'h39
`define BCD_OP_SENSE 6'h3A
`define BCD_MAX_LEN 4'hC
`define BCD_STORE_MAX 4'hD
`define BCD_LAST_DIGIT 4'hC
`define BCD_MAX_DIGIT 4'h9
`define BCD_NEG_SIGN 2'h2
`define BCD_RADIX 5'h0A
`define BCD_LEN_RESET 4'h0
`endif

// ==== hw/bcd_field_pkg.sv ====
// Types shared by the decimal field arithmetic unit
`include "bcd_field_regs.svh"
package bcd_field_pkg;
    typedef struct packed {
        logic valid;
        logic [5:0] op;
        logic [2:0] sub;
        logic [`BCD_CADDR_W-1:0] operand;
    } cmd_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic [`BCD_WADDR_W-1:0] addr;
        logic [3:0] char_en;
        logic [`BCD_WORD_W-1:0] wdata;
    } mem_req_type;

    typedef struct packed {
        logic ack;
        logic [`BCD_WORD_W-1:0] rdata;
    } mem_rsp_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_FETCH = 3'b001,
        ST_ARITH = 3'b010,
        ST_NEGATE = 3'b011,
        ST_STORE = 3'b100
    } fsm_type;

    typedef struct packed {
        fsm_type fsm;
        logic [5:0] op;
        logic [`BCD_LEN_W-1:0] len;
        logic acc_neg;
        logic [51:0] acc;
        logic opd_neg;
        logic [51:0] opd;
        logic [3:0] idx;
        logic [3:0] cnt;
        logic [`BCD_CADDR_W-1:0] addr;
        logic carry;
        logic fault;
        logic sensed;
        logic done;
        logic busy;
        mem_req_type mem;
    } state_type;
endpackage

// ==== hw/bcd_field_arithmetic_unit.sv ====
// Decimal field arithmetic unit: accumulator, length register, storage sequencing
`timescale 1ns/1ns
`default_nettype none
`include "bcd_field_regs.svh"
module bcd_field_arithmetic_unit (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire bcd_field_pkg::cmd_type i_cmd,
    input wire bcd_field_pkg::mem_rsp_type i_mem_rsp,
    output bcd_field_pkg::mem_req_type o_mem_req,
    output logic [`BCD_ACC_W-1:0] o_accum,
    output logic [`BCD_LEN_W-1:0] o_length,
    output logic o_fault,
    output logic o_sense_val,
    output logic o_busy,
    output logic o_done
);
    bcd_field_pkg::state_type state_r;
    bcd_field_pkg::state_type state_nxt;

    // Character position 0 is the most significant slot of the word
    function automatic logic [5:0] pick_char(input logic [23:0] w, input logic [1:0] pos);
        case (pos)
            2'h0: pick_char = w[23:18];
            2'h1: pick_char = w[17:12];
            2'h2: pick_char = w[11:6];
            default: pick_char = w[5:0];
        endcase
    endfunction

    function automatic bcd_field_pkg::mem_req_type mk_req(input logic wr, input logic [16:0] a,
                                                          input logic [5:0] ch);
        mk_req.valid = 1'b1;
        mk_req.write = wr;
        mk_req.addr = a[16:2];
        mk_req.char_en = 4'h8 >> a[1:0];
        mk_req.wdata = {4{ch}};
    endfunction

    logic [5:0] ch;
    logic [3:0] dig;
    logic [4:0] t;
    logic [3:0] a_d;
    logic [3:0] b_d;
    logic fault_set;
    logic fault_clr;
    logic same;
    logic [3:0] n;

    always_comb begin
        state_nxt = state_r;
        state_nxt.done = 1'b0;
        fault_set = 1'b0;
        fault_clr = 1'b0;
        ch = 6'h00;
        dig = 4'h0;
        t = 5'h00;
        a_d = 4'h0;
        b_d = 4'h0;
        n = 4'h0;
        same = (state_r.acc_neg == state_r.opd_neg);
        case (state_r.fsm)
            bcd_field_pkg::ST_IDLE: begin
                if (i_cmd.valid) begin
                    state_nxt.op = i_cmd.op;
                    state_nxt.idx = 4'h0;
                    state_nxt.carry = 1'b0;
                    state_nxt.done = 1'b1;
                    if (i_cmd.op == `BCD_OP_SETLEN && i_cmd.sub == `BCD_SUB_SETLEN) begin
                        state_nxt.len = i_cmd.operand[3:0];
                        fault_set = (i_cmd.operand[3:0] > `BCD_MAX_LEN);
                    end else if (i_cmd.op == `BCD_OP_SENSE) begin
                        state_nxt.sensed = state_r.fault;
                        fault_clr = 1'b1;
                    end else if (i_cmd.op == `BCD_OP_SHIFT) begin
                        // Shift digits, bit 4 selects left
                        if (i_cmd.operand[4]) begin
                            state_nxt.acc = state_r.acc << {i_cmd.operand[3:0], 2'b00};
                        end else begin
                            state_nxt.acc = state_r.acc >> {i_cmd.operand[3:0], 2'b00};
                        end
                    end else if (i_cmd.op == `BCD_OP_STORE) begin
                        n = (state_r.len > `BCD_STORE_MAX) ? `BCD_STORE_MAX : state_r.len;
                        if (n != 4'h0) begin
                            state_nxt.done = 1'b0;
                            state_nxt.cnt = n;
                            state_nxt.addr = i_cmd.operand + 17'(n) - 17'h00001;
                            state_nxt.fsm = bcd_field_pkg::ST_STORE;
                            state_nxt.mem = mk_req(1'b1, state_nxt.addr,
                                {(state_r.acc_neg ? `BCD_NEG_SIGN : 2'h0), state_r.acc[3:0]});
                        end
                    end else if (i_cmd.op == `BCD_OP_LOAD || i_cmd.op == `BCD_OP_ADD ||
                                 i_cmd.op == `BCD_OP_SUB) begin
                        n = (state_r.len > `BCD_MAX_LEN) ? `BCD_MAX_LEN : state_r.len;
                        state_nxt.opd = 52'h0;
                        state_nxt.opd_neg = 1'b0;
                        if (i_cmd.op == `BCD_OP_LOAD) begin
                            // Overflow digit and all others cleared
                            state_nxt.acc = 52'h0;
                            state_nxt.acc_neg = 1'b0;
                        end
                        if (n != 4'h0) begin
                            state_nxt.done = 1'b0;
                            state_nxt.cnt = n;
                            // First fetch at base+length-1
                            // A length of 13 skips the top character, keeping the lower twelve
                            state_nxt.addr = i_cmd.operand + 17'(state_r.len) - 17'h00001;
                            state_nxt.fsm = bcd_field_pkg::ST_FETCH;
                            state_nxt.mem = mk_req(1'b0, state_nxt.addr, 6'h00);
                        end
                    end
                end
            end
            bcd_field_pkg::ST_FETCH: begin
                if (i_mem_rsp.ack) begin
                    ch = pick_char(i_mem_rsp.rdata, state_r.addr[1:0]);
                    dig = (ch[3:0] > `BCD_MAX_DIGIT) ? 4'h0 : ch[3:0];
                    fault_set = (ch[3:0] > `BCD_MAX_DIGIT) || (state_r.idx != 4'h0 && ch[5:4] != 2'h0);
                    if (state_r.op == `BCD_OP_LOAD) begin
                        state_nxt.acc[{state_r.idx, 2'b00} +: 4] = dig;
                    end else begin
                        state_nxt.opd[{state_r.idx, 2'b00} +: 4] = dig;
                    end
                    if (state_r.idx == 4'h0) begin
                        if (state_r.op == `BCD_OP_LOAD) begin
                            state_nxt.acc_neg = (ch[5:4] == `BCD_NEG_SIGN);
                        end else begin
                            state_nxt.opd_neg = (ch[5:4] == `BCD_NEG_SIGN) ^ (state_r.op == `BCD_OP_SUB);
                        end
                    end
                    state_nxt.idx = state_r.idx + 4'h1;
                    if (state_r.idx + 4'h1 == state_r.cnt) begin
                        state_nxt.mem.valid = 1'b0;
                        state_nxt.idx = 4'h0;
                        if (state_r.op == `BCD_OP_LOAD) begin
                            state_nxt.fsm = bcd_field_pkg::ST_IDLE;
                            state_nxt.done = 1'b1;
                        end else begin
                            state_nxt.fsm = bcd_field_pkg::ST_ARITH;
                        end
                    end else begin
                        state_nxt.addr = state_r.addr - 17'h00001;
                        state_nxt.mem = mk_req(1'b0, state_nxt.addr, 6'h00);
                    end
                end
            end
            bcd_field_pkg::ST_ARITH, bcd_field_pkg::ST_NEGATE: begin
                // One digit per cycle with decimal carry
                if (state_r.fsm == bcd_field_pkg::ST_ARITH) begin
                    a_d = state_r.acc[{state_r.idx, 2'b00} +: 4];
                    b_d = state_r.opd[{state_r.idx, 2'b00} +: 4];
                end else begin
                    b_d = state_r.acc[{state_r.idx, 2'b00} +: 4];
                end
                if (state_r.fsm == bcd_field_pkg::ST_ARITH && same) begin
                    t = {1'b0, a_d} + {1'b0, b_d} + {4'h0, state_r.carry};
                    state_nxt.carry = (t > 5'(`BCD_MAX_DIGIT));
                    t = state_nxt.carry ? t - `BCD_RADIX : t;
                end else begin
                    t = {1'b0, a_d} + `BCD_RADIX - {1'b0, b_d} - {4'h0, state_r.carry};
                    state_nxt.carry = (t < `BCD_RADIX);
                    t = state_nxt.carry ? t : t - `BCD_RADIX;
                end
                state_nxt.acc[{state_r.idx, 2'b00} +: 4] = t[3:0];
                state_nxt.idx = state_r.idx + 4'h1;
                if (state_r.idx == `BCD_LAST_DIGIT) begin
                    state_nxt.idx = 4'h0;
                    // Magnitude went below zero: take the ten's complement
                    if (state_r.fsm == bcd_field_pkg::ST_ARITH && !same && state_nxt.carry) begin
                        state_nxt.fsm = bcd_field_pkg::ST_NEGATE;
                        state_nxt.acc_neg = ~state_r.acc_neg;
                    end else begin
                        state_nxt.fsm = bcd_field_pkg::ST_IDLE;
                        state_nxt.done = 1'b1;
                    end
                    // Borrow out of the top digit is used above before it is cleared
                    state_nxt.carry = 1'b0;
                end
            end
            bcd_field_pkg::ST_STORE: begin
                if (i_mem_rsp.ack) begin
                    state_nxt.idx = state_r.idx + 4'h1;
                    if (state_r.idx + 4'h1 == state_r.cnt) begin
                        state_nxt.mem.valid = 1'b0;
                        state_nxt.fsm = bcd_field_pkg::ST_IDLE;
                        state_nxt.done = 1'b1;
                    end else begin
                        state_nxt.addr = state_r.addr - 17'h00001;
                        state_nxt.mem = mk_req(1'b1, state_nxt.addr,
                            {2'h0, state_r.acc[{state_nxt.idx, 2'b00} +: 4]});
                    end
                end
            end
            default: begin
                state_nxt.fsm = bcd_field_pkg::ST_IDLE;
                state_nxt.mem.valid = 1'b0;
            end
        endcase
        // Set wins over a clear in the same cycle
        state_nxt.fault = (state_r.fault & ~fault_clr) | fault_set;
        state_nxt.busy = (state_nxt.fsm != bcd_field_pkg::ST_IDLE);
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state_r <= '0;
            state_r.fsm <= bcd_field_pkg::ST_IDLE;
            state_r.len <= `BCD_LEN_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign o_accum = {state_r.acc_neg, state_r.acc};
    assign o_length = state_r.len;
    assign o_fault = state_r.fault;
    assign o_sense_val = state_r.sensed;
    assign o_busy = state_r.busy;
    assign o_done = state_r.done;
    assign o_mem_req = state_r.mem;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    logic idle_cmd;
    assign idle_cmd = !state_r.busy && i_cmd.valid;

    property p_setlen;
        idle_cmd && i_cmd.op == `BCD_OP_SETLEN && i_cmd.sub == `BCD_SUB_SETLEN
            |=> o_length == $past(i_cmd.operand[3:0]) && o_done;
    endproperty
    a_setlen: assert property (p_setlen) else $error("length not written");

    property p_oversize;
        idle_cmd && i_cmd.op == `BCD_OP_SETLEN && i_cmd.sub == `BCD_SUB_SETLEN && i_cmd.operand[3:0] > 4'hC
            |=> o_fault;
    endproperty
    a_oversize: assert property (p_oversize) else $error("oversize length did not fault");

    property p_sense;
        idle_cmd && i_cmd.op == `BCD_OP_SENSE |=> !o_fault && o_sense_val == $past(o_fault);
    endproperty
    a_sense: assert property (p_sense) else $error("sense did not clear fault");

    property p_load_first;
        idle_cmd && i_cmd.op == `BCD_OP_LOAD && o_length inside {[4'h1:4'hC]}
            |=> o_mem_req.valid && !o_mem_req.write && state_r.addr == $past(i_cmd.operand) + 17'($past(o_length)) - 17'h1;
    endproperty
    a_load_first: assert property (p_load_first) else $error("load start address wrong");

    property p_load13;
        idle_cmd && i_cmd.op != `BCD_OP_STORE && i_cmd.op != `BCD_OP_SETLEN && i_cmd.op != `BCD_OP_SENSE &&
            i_cmd.op != `BCD_OP_SHIFT && o_length == 4'hD
            |=> (state_r.cnt == 4'hC && state_r.addr == $past(i_cmd.operand) + 17'hC) || o_done;
    endproperty
    a_load13: assert property (p_load13) else $error("length 13 used more than twelve");

    property p_store13;
        idle_cmd && i_cmd.op == `BCD_OP_STORE && o_length == 4'hD
            |=> o_mem_req.valid && o_mem_req.write && state_r.addr == $past(i_cmd.operand) + 17'hC;
    endproperty
    a_store13: assert property (p_store13) else $error("length 13 store start wrong");

    property p_load_ovf;
        o_done && state_r.op == `BCD_OP_LOAD |-> o_accum[51:48] == 4'h0;
    endproperty
    a_load_ovf: assert property (p_load_ovf) else $error("overflow digit loaded");

    property p_write_only_store;
        o_mem_req.valid && o_mem_req.write |-> state_r.fsm == bcd_field_pkg::ST_STORE;
    endproperty
    a_write_only_store: assert property (p_write_only_store) else $error("write outside store");

    property p_illegal_digit;
        state_r.fsm == bcd_field_pkg::ST_FETCH && i_mem_rsp.ack &&
            (pick_char(i_mem_rsp.rdata, state_r.addr[1:0]) & 6'h0F) > 6'h09 |=> o_fault;
    endproperty
    a_illegal_digit: assert property (p_illegal_digit) else $error("bad character not faulted");

    c_load: cover property (o_done && state_r.op == `BCD_OP_LOAD);
    c_negate: cover property (state_r.fsm == bcd_field_pkg::ST_NEGATE);
    c_store13: cover property (o_done && state_r.op == `BCD_OP_STORE && state_r.cnt == 4'hD);
endmodule
`default_nettype wire

// ==== verification/bcd_mem_model.sv ====
// Main storage model answering the unit's character requests
`timescale 1ns/1ns
`default_nettype none
`include "bcd_field_regs.svh"
module bcd_mem_model (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire bcd_field_pkg::mem_req_type i_mem_req,
    input wire logic [3:0] i_delay,
    output bcd_field_pkg::mem_rsp_type o_mem_rsp
);
    logic [`BCD_WORD_W-1:0] mem [0:255];
    logic [3:0] wait_r;
    logic take;

    // Answer once per request, after the programmed number of wait cycles
    assign take = i_mem_req.valid && !o_mem_rsp.ack && (wait_r >= i_delay);

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_mem_rsp <= '0;
            wait_r <= 4'h0;
        end else if (take) begin
            o_mem_rsp.ack <= 1'b1;
            o_mem_rsp.rdata <= mem[i_mem_req.addr[7:0]];
            wait_r <= 4'h0;
        end else begin
            // Read data is only good with ack; otherwise it keeps changing
            o_mem_rsp.ack <= 1'b0;
            o_mem_rsp.rdata <= ~o_mem_rsp.rdata;
            wait_r <= i_mem_req.valid ? wait_r + 4'h1 : 4'h0;
        end
    end

    always @(posedge i_core_clk) begin
        if (!i_rst && take && i_mem_req.write) begin
            for (int k = 0; k < 4; k++) begin
                if (i_mem_req.char_en[k]) begin
                    mem[i_mem_req.addr[7:0]][6*k +: 6] <= i_mem_req.wdata[6*k +: 6];
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== verification/bcd_field_arithmetic_unit_tb.sv ====
// Self-checking bench for the decimal field arithmetic unit
`timescale 1ns/1ns
`default_nettype none
`include "bcd_field_regs.svh"
module bcd_field_arithmetic_unit_tb;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    bcd_field_pkg::cmd_type cmd = '0;
    bcd_field_pkg::mem_rsp_type mem_rsp;
    bcd_field_pkg::mem_req_type mem_req;
    logic [`BCD_ACC_W-1:0] accum;
    logic [`BCD_LEN_W-1:0] length;
    logic fault, sense_val, busy, done;
    logic [3:0] delay = 4'h0;
    int num_errors = 0;
    int tests_run = 0;

    always #5 i_core_clk = ~i_core_clk;

    bcd_field_arithmetic_unit dut_u (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_cmd(cmd),
        .i_mem_rsp(mem_rsp), .o_mem_req(mem_req), .o_accum(accum), .o_length(length),
        .o_fault(fault), .o_sense_val(sense_val), .o_busy(busy), .o_done(done));
    bcd_mem_model mem_u (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_mem_req(mem_req),
        .i_delay(delay), .o_mem_rsp(mem_rsp));

    task automatic check(input logic [52:0] seen, input logic [52:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("mismatches %0d of %0d checks", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // One command, then a bounded wait for its completion pulse
    task automatic issue(input logic [5:0] op, input logic [2:0] sub, input logic [16:0] opd);
        @(posedge i_core_clk);
        #1;
        cmd = '{1'b1, op, sub, opd};
        @(posedge i_core_clk);
        #1;
        cmd.valid = 1'b0;
        wait_done();
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        while (done !== 1'b1 && n < 200) begin
            @(posedge i_core_clk);
            #1;
            n++;
        end
        if (n >= 200) begin
            num_errors++;
            $display("FAIL %0t command never completed", $time);
            results();
        end
    endtask

    task automatic setlen(input logic [3:0] v);
        issue(`BCD_OP_SETLEN, `BCD_SUB_SETLEN, {13'h0, v});
    endtask

    task automatic sense();
        issue(`BCD_OP_SENSE, 3'h0, 17'h0);
    endtask

    task automatic put_char(input int a, input logic [5:0] ch);
        mem_u.mem[a >> 2][23 - 6 * (a % 4) -: 6] = ch;
    endtask

    function automatic logic [5:0] get_char(input int a);
        return mem_u.mem[a >> 2][23 - 6 * (a % 4) -: 6];
    endfunction

    // Field with lowest character at base+len-1, optional bad character at digit bad_pos
    task automatic put_field(input int base, input int len, input logic [51:0] val, input logic neg,
                             input int bad_pos, input logic [5:0] bad_ch);
        logic [5:0] ch;
        for (int i = 0; i < len; i++) begin
            ch = {(i == 0 && neg) ? `BCD_NEG_SIGN : 2'h0, val[4*i +: 4]};
            if (i == bad_pos) begin
                ch = bad_ch;
            end
            put_char(base + len - 1 - i, ch);
        end
    endtask

    initial begin
        for (int w = 0; w < 256; w++) begin
            mem_u.mem[w] = 24'h000000;
        end
        put_field(5, 11, 52'h849109825, 1'b1, 15, 6'h00);
        put_char(16, 6'h09);
        put_field(20, 4, 52'h1234, 1'b0, 2, 6'h0B);
        put_field(24, 4, 52'h5678, 1'b0, 1, 6'h17);
        put_field(28, 13, 52'h1999999999999, 1'b0, 15, 6'h00);
        put_field(44, 12, 52'h1, 1'b0, 5, 6'h0A);
        put_char(59, 6'h15);
        put_char(73, 6'h15);
        put_field(80, 2, 52'h25, 1'b0, 15, 6'h00);
        put_field(84, 2, 52'h40, 1'b0, 15, 6'h00);
        repeat (8) @(posedge i_core_clk);
        #1;
        i_rst = 1'b0;
        check(53'(length), 53'(`BCD_LEN_RESET));
        check(accum, 53'h0);
        setlen(4'hB);
        check(53'(length), 53'hB);
        check(53'(fault), 53'h0);
        issue(`BCD_OP_LOAD, 3'h0, 17'd5);
        check(accum, {1'b1, 52'h849109825});
        check(53'(fault), 53'h0);
        setlen(4'h4);
        issue(`BCD_OP_LOAD, 3'h0, 17'd20);
        check(accum, {1'b0, 52'h1034});
        check(53'(fault), 53'h1);
        sense();
        check({52'h0, sense_val}, 53'h1);
        check(53'(fault), 53'h0);
        sense();
        check(53'(sense_val), 53'h0);
        issue(`BCD_OP_LOAD, 3'h0, 17'd24);
        check(accum, {1'b0, 52'h5678});
        check(53'(fault), 53'h1);
        sense();
        setlen(`BCD_MAX_LEN);
        check(53'(fault), 53'h0);
        setlen(`BCD_STORE_MAX);
        check(53'(fault), 53'h1);
        sense();
        issue(`BCD_OP_LOAD, 3'h0, 17'd28);
        check(accum, {1'b0, 52'h0999999999999});
        check(53'(fault), 53'h0);
        setlen(`BCD_MAX_LEN);
        delay = 4'h3;
        issue(`BCD_OP_ADD, 3'h0, 17'd44);
        check(accum, {1'b0, 52'h1000000000000});
        check(53'(fault), 53'h1);
        setlen(`BCD_STORE_MAX);
        sense();
        issue(`BCD_OP_STORE, 3'h0, 17'd60);
        for (int a = 59; a < 74; a++) begin
            check(53'(get_char(a)), (a == 60) ? 53'h1 : ((a == 59 || a == 73) ? 53'h15 : 53'h0));
        end
        delay = 4'h0;
        setlen(4'h2);
        // A command offered while busy is dropped
        @(posedge i_core_clk);
        #1;
        cmd = '{1'b1, `BCD_OP_LOAD, 3'h0, 17'd80};
        @(posedge i_core_clk);
        #1;
        cmd = '{1'b1, `BCD_OP_SETLEN, `BCD_SUB_SETLEN, 17'h00005};
        check(53'(busy), 53'h1);
        @(posedge i_core_clk);
        #1;
        cmd.valid = 1'b0;
        wait_done();
        check(53'(length), 53'h2);
        check(accum, {1'b0, 52'h25});
        issue(`BCD_OP_SUB, 3'h0, 17'd84);
        check(accum, {1'b1, 52'h15});
        issue(`BCD_OP_SHIFT, 3'h0, 17'h11);
        check(accum, {1'b1, 52'h150});
        issue(`BCD_OP_STORE, 3'h0, 17'd90);
        check(53'(get_char(90)), 53'h05);
        check(53'(get_char(91)), 53'h20);
        check(53'(get_char(92)), 53'h0);
        issue(`BCD_OP_SHIFT, 3'h0, 17'h02);
        check(accum, {1'b1, 52'h1});
        check(53'(busy), 53'h0);
        results();
    end
endmodule
`default_nettype wire
